// ### ttl_map.svh
`ifndef TTL_MAP_SVH
`define TTL_MAP_SVH

// Frame characters
`define TTL_CH_START 8'h3E
`define TTL_CH_END 8'h0D
`define TTL_CH_PRINT_MIN 8'h20
`define TTL_CH_DISPLAY 8'h4B
`define TTL_CH_STATUS 8'h4D
`define TTL_CH_ACCEPT 8'h41
`define TTL_CH_REFUSE 8'h4E
`define TTL_CH_ZERO 8'h30
`define TTL_CH_NINE 8'h39
`define TTL_CH_UC_A 8'h41
`define TTL_CH_UC_F 8'h46
`define TTL_CH_LC_A 8'h61
`define TTL_CH_LC_F 8'h66
`define TTL_HEX_UC_BASE 8'h37
`define TTL_HEX_LC_BASE 8'h57
`define TTL_COL_B 8'h62
`define TTL_COL_G 8'h67
`define TTL_COL_Y 8'h79
`define TTL_COL_R 8'h72
`define TTL_COL_F 8'h66
`define TTL_CASE_BIT 8'h20

// Field lengths
`define TTL_DATA_MIN 3'h2
`define TTL_DATA_MAX 3'h6
`define TTL_DISP_MIN 3'h5
`define TTL_HDR_LEN 5'h06
`define TTL_RX_MIN 5'h05
`define TTL_RX_BUF 21
`define TTL_RX_CNT_MAX 5'h16

// Register byte offsets
`define TTL_REG_CTRL 8'h00
`define TTL_REG_TXN 8'h04
`define TTL_REG_SIGN 8'h08
`define TTL_REG_CMD 8'h0C
`define TTL_REG_DATA0 8'h10
`define TTL_REG_DATA1 8'h14
`define TTL_REG_STATUS 8'h18
`define TTL_REG_RXID 8'h1C
`define TTL_REG_RXD0 8'h20
`define TTL_REG_RXD1 8'h24
`define TTL_REG_RXD2 8'h28
`define TTL_REG_RXD3 8'h2C

// Control and status bit positions
`define TTL_CTRL_SEND 0
`define TTL_CTRL_ABORT 1
`define TTL_ST_DONE 0
`define TTL_ST_CKS_ERR 1
`define TTL_ST_ID_ERR 2
`define TTL_ST_FMT_ERR 3
`define TTL_ST_CFG_ERR 4
`define TTL_ST_BUSY 5
`define TTL_ST_RESP_LSB 8
`define TTL_ST_LEN_LSB 16

`endif

// ### ttl_pkg.sv
package ttl_pkg;
	typedef logic [7:0] ttl_byte_t;
	typedef enum logic [1:0] {
		tx_idle = 2'b00,
		tx_send = 2'b01,
		tx_wait = 2'b10
	} ttl_tx_state_t;
	typedef enum logic {
		rx_hunt = 1'b0,
		rx_body = 1'b1
	} ttl_rx_state_t;
endpackage

// ### ttl_hex_enc.sv
`timescale 1ns/1ps
`default_nettype none
`include "ttl_map.svh"
module ttl_hex_enc (
	input wire logic [3:0] nibble,
	output logic [7:0] ascii
);
	// Upper-case letters only on the way out
	always_comb
	begin
		if (nibble < 4'hA)
			ascii = `TTL_CH_ZERO + {4'h0, nibble};
		else
			ascii = `TTL_HEX_UC_BASE + {4'h0, nibble};
	end
endmodule
`default_nettype wire

// ### ttl_hex_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "ttl_map.svh"
module ttl_hex_dec (
	input wire logic [7:0] ascii,
	output logic [3:0] nibble,
	output logic valid
);
	logic [7:0] diff;
	always_comb
	begin
		diff = 8'h00;
		valid = 1'b1;
		if (ascii >= `TTL_CH_ZERO && ascii <= `TTL_CH_NINE)
			diff = ascii - `TTL_CH_ZERO;
		else if (ascii >= `TTL_CH_UC_A && ascii <= `TTL_CH_UC_F)
			diff = ascii - `TTL_HEX_UC_BASE;
		else if (ascii >= `TTL_CH_LC_A && ascii <= `TTL_CH_LC_F)
			diff = ascii - `TTL_HEX_LC_BASE;
		else
			valid = 1'b0;
		nibble = diff[3:0];
	end
endmodule
`default_nettype wire

// ### ttl_link_host.sv
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ttl_map.svh"
// Overview of operation
// - Every frame opens with 0x3E; receiver restarts on it, excludes it from sum.
// - Every frame ends with one 0x0D right after the checksum digits.
// - Only printable bytes are sent or accepted, except the closing 0x0D.
// - Command is start, id, sign, command, 2-6 data, checksum, carriage return.
// - Command character is 0x4B display or 0x4D status query, nothing else.
// - Sign number and two-digit fields are two decimal digits, zero padded.
// - Checksum is the byte sum after start, before checksum, modulo 256.
// - Checksum goes out as two hex digits, high nibble first.
// - Master matches replies by echoed id; ids need no sequence.
// - Segment numbers start at 01 from the bottom of the sign.
// - Numbers travel as decimal digit characters, one byte per digit.
// - Display data is segment, time, colour b g y r or fr, any case.
module ttl_link_host
	import ttl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output ttl_pkg::ttl_byte_t tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire ttl_pkg::ttl_byte_t rx_data,
	input wire logic rx_valid
);
	import ttl_pkg::*;

	ttl_tx_state_t tx_state, next_tx_state;
	ttl_rx_state_t rx_state, next_rx_state;
	logic [4:0] pos, next_pos;
	logic [7:0] tx_sum, next_tx_sum;
	ttl_byte_t next_tx_data;
	logic next_tx_valid;
	logic [15:0] cfg_id, next_cfg_id, cfg_sign, next_cfg_sign;
	logic [7:0] cfg_cmd, next_cfg_cmd;
	logic [2:0] cfg_len, next_cfg_len;
	logic [47:0] cfg_dat, next_cfg_dat;
	logic [7:0] rx_buf [0:`TTL_RX_BUF-1];
	logic [7:0] next_rx_buf [0:`TTL_RX_BUF-1];
	logic [4:0] rx_cnt, next_rx_cnt;
	logic [7:0] rx_sum, next_rx_sum, rx_p1, next_rx_p1, rx_p2, next_rx_p2;
	logic rx_bad, next_rx_bad;
	logic [4:0] status, next_status;
	logic [7:0] rx_resp, next_rx_resp;
	logic [4:0] rx_len, next_rx_len;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic [7:0] cks_hi_ch, cks_lo_ch;
	logic [3:0] dec_hi, dec_lo;
	logic dec_hi_ok, dec_lo_ok;
	logic rx_done_ev;

	// Encoders see the sum as it will stand after the current byte goes
	ttl_hex_enc u_enc_hi (.nibble(next_tx_sum[7:4]), .ascii(cks_hi_ch));
	ttl_hex_enc u_enc_lo (.nibble(next_tx_sum[3:0]), .ascii(cks_lo_ch));
	ttl_hex_dec u_dec_hi (.ascii(rx_p2), .nibble(dec_hi), .valid(dec_hi_ok));
	ttl_hex_dec u_dec_lo (.ascii(rx_p1), .nibble(dec_lo), .valid(dec_lo_ok));

	function automatic logic is_digit(input logic [7:0] c);
		return c >= `TTL_CH_ZERO && c <= `TTL_CH_NINE;
	endfunction

	function automatic logic [7:0] dat_ch(input logic [47:0] d, input logic [4:0] k);
		return d[47 - 8 * k -: 8];
	endfunction

	// Frame contents are checked at SEND only, so a setup rewritten mid-frame reaches the link unchecked
	function automatic logic cfg_ok(input logic [15:0] id, input logic [15:0] sg,
		input logic [7:0] cm, input logic [2:0] ln, input logic [47:0] d);
		logic ok;
		logic [7:0] c0;
		logic [7:0] c1;
		ok = id[15:8] >= `TTL_CH_PRINT_MIN && id[7:0] >= `TTL_CH_PRINT_MIN;
		ok = ok && is_digit(sg[15:8]) && is_digit(sg[7:0]);
		ok = ok && ln >= `TTL_DATA_MIN && ln <= `TTL_DATA_MAX;
		ok = ok && is_digit(d[47:40]) && is_digit(d[39:32]);
		ok = ok && !(d[47:40] == `TTL_CH_ZERO && d[39:32] == `TTL_CH_ZERO);
		c0 = d[15:8] | `TTL_CASE_BIT;
		c1 = d[7:0] | `TTL_CASE_BIT;
		if (cm == `TTL_CH_STATUS)
			ok = ok && ln == `TTL_DATA_MIN;
		else if (cm == `TTL_CH_DISPLAY)
		begin
			ok = ok && ln >= `TTL_DISP_MIN && is_digit(d[31:24]) && is_digit(d[23:16]);
			if (ln == `TTL_DISP_MIN)
				ok = ok && (c0 == `TTL_COL_B || c0 == `TTL_COL_G || c0 == `TTL_COL_Y
					|| c0 == `TTL_COL_R);
			else
				ok = ok && c0 == `TTL_COL_F && c1 == `TTL_COL_R;
		end
		else
			ok = 1'b0;
		return ok;
	endfunction

	// Byte at a given frame position; checksum digits come from the encoders
	function automatic logic [7:0] frame_byte(input logic [4:0] p, input logic [15:0] id,
		input logic [15:0] sg, input logic [7:0] cm, input logic [2:0] ln,
		input logic [47:0] d, input logic [7:0] hi, input logic [7:0] lo);
		logic [4:0] dend;
		dend = `TTL_HDR_LEN + {2'b00, ln};
		case (p)
			5'h00: return `TTL_CH_START;
			5'h01: return id[15:8];
			5'h02: return id[7:0];
			5'h03: return sg[15:8];
			5'h04: return sg[7:0];
			5'h05: return cm;
			default:
			begin
				if (p < dend)
					return dat_ch(d, p - `TTL_HDR_LEN);
				else if (p == dend)
					return hi;
				else if (p == dend + 5'h01)
					return lo;
				else
					return `TTL_CH_END;
			end
		endcase
	endfunction

	logic a_phase;
	logic [4:0] st_clr, st_set;
	logic [4:0] dend, last_pos;
	logic [7:0] rx_cks;
	assign a_phase = hsel && hready && htrans[1];
	assign dend = `TTL_HDR_LEN + {2'b00, cfg_len};
	assign last_pos = dend + 5'h02;
	assign rx_cks = rx_sum - rx_p1 - rx_p2;
	assign rx_done_ev = rx_valid && rx_state == rx_body && rx_data == `TTL_CH_END;

	always_comb
	begin
		next_tx_state = tx_state;
		next_pos = pos;
		next_tx_sum = tx_sum;
		next_tx_data = tx_data;
		next_tx_valid = tx_valid;
		next_cfg_id = cfg_id;
		next_cfg_sign = cfg_sign;
		next_cfg_cmd = cfg_cmd;
		next_cfg_len = cfg_len;
		next_cfg_dat = cfg_dat;
		next_rx_state = rx_state;
		next_rx_buf = rx_buf;
		next_rx_cnt = rx_cnt;
		next_rx_sum = rx_sum;
		next_rx_p1 = rx_p1;
		next_rx_p2 = rx_p2;
		next_rx_bad = rx_bad;
		next_rx_resp = rx_resp;
		next_rx_len = rx_len;
		next_wr_pend = a_phase && hwrite;
		next_wr_addr = a_phase ? haddr[7:0] : wr_addr;
		st_clr = 5'h00;
		st_set = 5'h00;

		// Register writes land in the data phase
		if (wr_pend)
		begin
			case (wr_addr)
				`TTL_REG_CTRL:
				begin
					if (hwdata[`TTL_CTRL_ABORT])
					begin
						next_tx_state = tx_idle;
						next_tx_valid = 1'b0;
					end
					else if (hwdata[`TTL_CTRL_SEND] && tx_state == tx_idle)
					begin
						if (cfg_ok(cfg_id, cfg_sign, cfg_cmd, cfg_len, cfg_dat))
						begin
							next_tx_state = tx_send;
							next_pos = 5'h00;
							next_tx_sum = 8'h00;
							next_tx_data = `TTL_CH_START;
							next_tx_valid = 1'b1;
						end
						else
							st_set[`TTL_ST_CFG_ERR] = 1'b1;
					end
				end
				`TTL_REG_TXN: next_cfg_id = hwdata[15:0];
				`TTL_REG_SIGN: next_cfg_sign = hwdata[15:0];
				`TTL_REG_CMD:
				begin
					next_cfg_cmd = hwdata[7:0];
					next_cfg_len = hwdata[10:8];
				end
				`TTL_REG_DATA0: next_cfg_dat[47:16] = hwdata;
				`TTL_REG_DATA1: next_cfg_dat[15:0] = hwdata[15:0];
				`TTL_REG_STATUS: st_clr = hwdata[4:0];
				default: ;
			endcase
		end

		// Transmit one byte per accepted handshake
		if (tx_state == tx_send && tx_valid && tx_ready)
		begin
			if (pos >= 5'h01 && pos < dend)
				next_tx_sum = tx_sum + tx_data;
			if (pos == last_pos)
			begin
				next_tx_valid = 1'b0;
				next_tx_state = tx_wait;
			end
			else
			begin
				next_pos = pos + 5'h01;
				next_tx_data = frame_byte(pos + 5'h01, cfg_id, cfg_sign, cfg_cmd, cfg_len,
					cfg_dat, cks_hi_ch, cks_lo_ch);
			end
		end

		// Receive side; bytes outside a frame are dropped
		if (rx_valid)
		begin
			if (rx_data == `TTL_CH_START)
			begin
				next_rx_state = rx_body;
				next_rx_cnt = 5'h00;
				next_rx_sum = 8'h00;
				next_rx_p1 = 8'h00;
				next_rx_p2 = 8'h00;
				next_rx_bad = 1'b0;
			end
			else if (rx_state == rx_body)
			begin
				if (rx_data == `TTL_CH_END)
				begin
					next_rx_state = rx_hunt;
					st_set[`TTL_ST_DONE] = 1'b1;
					next_rx_resp = rx_buf[2];
					next_rx_len = rx_cnt - `TTL_RX_MIN;
					if (rx_bad || rx_cnt < `TTL_RX_MIN || (rx_buf[2] != `TTL_CH_ACCEPT
						&& rx_buf[2] != `TTL_CH_REFUSE))
						st_set[`TTL_ST_FMT_ERR] = 1'b1;
					else if (!dec_hi_ok || !dec_lo_ok || rx_cks != {dec_hi, dec_lo})
						st_set[`TTL_ST_CKS_ERR] = 1'b1;
					else if ({rx_buf[0], rx_buf[1]} != cfg_id)
						st_set[`TTL_ST_ID_ERR] = 1'b1;
					if (tx_state == tx_wait)
						next_tx_state = tx_idle;
				end
				else if (rx_data < `TTL_CH_PRINT_MIN)
					next_rx_bad = 1'b1;
				else
				begin
					if (rx_cnt < 5'(`TTL_RX_BUF))
						next_rx_buf[rx_cnt] = rx_data;
					else
						next_rx_bad = 1'b1;
					if (rx_cnt != `TTL_RX_CNT_MAX)
						next_rx_cnt = rx_cnt + 5'h01;
					next_rx_sum = rx_sum + rx_data;
					next_rx_p2 = rx_p1;
					next_rx_p1 = rx_data;
				end
			end
		end

		// A flag raised in the cycle software clears it survives
		next_status = (status & ~st_clr) | st_set;

		next_hrdata = 32'h0000_0000;
		if (a_phase && !hwrite)
		begin
			case (haddr[7:0])
				`TTL_REG_TXN: next_hrdata = {16'h0000, cfg_id};
				`TTL_REG_SIGN: next_hrdata = {16'h0000, cfg_sign};
				`TTL_REG_CMD: next_hrdata = {21'h000000, cfg_len, cfg_cmd};
				`TTL_REG_DATA0: next_hrdata = cfg_dat[47:16];
				`TTL_REG_DATA1: next_hrdata = {16'h0000, cfg_dat[15:0]};
				`TTL_REG_STATUS: next_hrdata = {11'h000, rx_len, rx_resp, 2'b00,
					tx_state != tx_idle, status};
				`TTL_REG_RXID: next_hrdata = {16'h0000, rx_buf[0], rx_buf[1]};
				`TTL_REG_RXD0: next_hrdata = {rx_buf[3], rx_buf[4], rx_buf[5], rx_buf[6]};
				`TTL_REG_RXD1: next_hrdata = {rx_buf[7], rx_buf[8], rx_buf[9], rx_buf[10]};
				`TTL_REG_RXD2: next_hrdata = {rx_buf[11], rx_buf[12], rx_buf[13], rx_buf[14]};
				`TTL_REG_RXD3: next_hrdata = {rx_buf[15], rx_buf[16], rx_buf[17], rx_buf[18]};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tx_state <= tx_idle;
			pos <= 5'h00;
			tx_sum <= 8'h00;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			cfg_id <= 16'h3030;
			cfg_sign <= 16'h3031;
			cfg_cmd <= `TTL_CH_STATUS;
			cfg_len <= `TTL_DATA_MIN;
			cfg_dat <= 48'h3031_0000_0000;
			rx_state <= rx_hunt;
			for (int i = 0; i < `TTL_RX_BUF; i++)
				rx_buf[i] <= 8'h00;
			rx_cnt <= 5'h00;
			rx_sum <= 8'h00;
			rx_p1 <= 8'h00;
			rx_p2 <= 8'h00;
			rx_bad <= 1'b0;
			status <= 5'h00;
			rx_resp <= 8'h00;
			rx_len <= 5'h00;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			tx_state <= next_tx_state;
			pos <= next_pos;
			tx_sum <= next_tx_sum;
			tx_data <= next_tx_data;
			tx_valid <= next_tx_valid;
			cfg_id <= next_cfg_id;
			cfg_sign <= next_cfg_sign;
			cfg_cmd <= next_cfg_cmd;
			cfg_len <= next_cfg_len;
			cfg_dat <= next_cfg_dat;
			rx_state <= next_rx_state;
			rx_buf <= next_rx_buf;
			rx_cnt <= next_rx_cnt;
			rx_sum <= next_rx_sum;
			rx_p1 <= next_rx_p1;
			rx_p2 <= next_rx_p2;
			rx_bad <= next_rx_bad;
			status <= next_status;
			rx_resp <= next_rx_resp;
			rx_len <= next_rx_len;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	start_byte_a: assert property ($rose(tx_valid) |-> tx_data == `TTL_CH_START)
		else $error("frame did not open with start byte");
	end_byte_a: assert property (tx_valid && tx_ready && pos == last_pos
		|-> tx_data == `TTL_CH_END ##1 !tx_valid && tx_state == tx_wait)
		else $error("frame did not close with carriage return");
	printable_a: assert property (tx_valid && tx_data < `TTL_CH_PRINT_MIN
		|-> tx_data == `TTL_CH_END && pos == last_pos)
		else $error("control byte inside frame");
	cmd_char_a: assert property (tx_valid && pos == 5'h05
		|-> tx_data == `TTL_CH_DISPLAY || tx_data == `TTL_CH_STATUS)
		else $error("bad command character sent");
	sign_digit_a: assert property (tx_valid && (pos == 5'h03 || pos == 5'h04)
		|-> is_digit(tx_data))
		else $error("sign number not decimal");
	cks_digit_a: assert property (tx_valid && pos == dend
		|-> tx_data == (tx_sum[7:4] < 4'hA ? `TTL_CH_ZERO + {4'h0, tx_sum[7:4]}
			: `TTL_HEX_UC_BASE + {4'h0, tx_sum[7:4]}))
		else $error("checksum high digit wrong");
	seg_field_a: assert property (tx_valid && pos == 5'h06
		|-> is_digit(tx_data) && $stable(cfg_dat) throughout (tx_valid [*2]))
		else $error("segment field malformed");
	// The first byte must be taken too, or a stalled start would shift the count
	frame_len_a: assert property ($rose(tx_valid) && tx_ready ##1 (tx_valid && tx_ready) [*2]
		|=> pos == 5'h03 && tx_state == tx_send)
		else $error("frame position lost");
	reply_done_a: assert property (rx_done_ev |=> status[`TTL_ST_DONE]
		&& tx_state != tx_wait)
		else $error("reply end not reported");

	send_cv: cover property (tx_valid && tx_ready && pos == last_pos);
	reply_ok_cv: cover property (rx_done_ev ##1 !status[`TTL_ST_CKS_ERR]);
	cks_bad_cv: cover property ($rose(status[`TTL_ST_CKS_ERR]));
	restart_cv: cover property (rx_valid && rx_state == rx_body && rx_data == `TTL_CH_START);
endmodule
`default_nettype wire

// ### ttl_sign_model.sv
`timescale 1ns/1ps
`default_nettype none
module ttl_sign_model
	import ttl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire ttl_pkg::ttl_byte_t tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output ttl_pkg::ttl_byte_t rx_data,
	output logic rx_valid,
	input wire logic slow,
	input wire logic [1:0] fault
);
	import ttl_pkg::*;
	ttl_byte_t cmd [0:31];
	int n;
	event got;

	function automatic ttl_byte_t hx(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
	endfunction

	function automatic logic [3:0] dh(input ttl_byte_t c);
		return (c < 8'h3A) ? c[3:0] : c[3:0] + 4'h9;
	endfunction

	// Slow mode drops tx_ready every other cycle and leaves an idle cycle after each reply byte
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			tx_ready <= 1'b0;
			n = 0;
		end
		else
		begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (tx_valid && tx_ready)
			begin
				if (tx_data == 8'h3E)
					n = 0;
				if (n < 32)
					cmd[n] = tx_data;
				n = n + 1;
				if (tx_data == 8'h0D)
					->got;
			end
		end
	end

	task automatic put(input ttl_byte_t b);
		@(posedge core_clk);
		rx_data <= b;
		rx_valid <= 1'b1;
		if (slow)
		begin
			@(posedge core_clk);
			rx_data <= ~b;
			rx_valid <= 1'b0;
		end
	endtask

	// Faults only when the bench asks: 1 bad sum, 2 wrong id, 3 junk and restart
	initial
	begin
		ttl_byte_t r [$];
		logic [7:0] s;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		forever
		begin
			@(got);
			s = 8'h00;
			for (int i = 1; i < n - 3; i++)
				s = s + cmd[i];
			r = {8'h3E, cmd[1], cmd[2]};
			if (fault == 2'h2)
				r[1] = 8'h7A;
			if ({dh(cmd[n-3]), dh(cmd[n-2])} != s)
				r = {r, 8'h4E, 8'h30, 8'h38};
			else if ({cmd[3], cmd[4]} != 16'h3031)
				r = {r, 8'h4E, 8'h30, 8'h33};
			else if (cmd[5] == 8'h4B)
				r.push_back(8'h41);
			else if (cmd[5] != 8'h4D)
				r = {r, 8'h4E, 8'h30, 8'h34};
			else
			begin
				r.push_back(8'h41);
				for (int i = 0; i < 16; i++)
					r.push_back(8'h41 + i);
			end
			s = 8'h00;
			for (int i = 1; i < r.size(); i++)
				s = s + r[i];
			if (fault == 2'h1)
				s = ~s;
			r = {r, hx(s[7:4]), hx(s[3:0]), 8'h0D};
			if (fault == 2'h3)
				r = {8'h55, 8'h3E, 8'h39, r};
			foreach (r[i])
				put(r[i]);
			@(posedge core_clk);
			rx_valid <= 1'b0;
			rx_data <= ~rx_data;
		end
	end
endmodule
`default_nettype wire

// ### ttl_link_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ttl_link_host_tb;
	import ttl_pkg::*;
	logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, slow;
	logic tx_valid, tx_ready, rx_valid;
	logic [31:0] haddr, hwdata, hrdata, rd_s;
	logic [1:0] htrans, fault;
	logic [2:0] hsize;
	ttl_byte_t tx_data, rx_data;
	ttl_byte_t txq [$];
	logic rdy_s;
	int n_errors = 0;
	int n_checks = 0;
	logic [47:0] kd [5] = '{48'h303130346700, 48'h303235356200, 48'h303339395900,
		48'h303130307200, 48'h303431326672};
	logic [31:0] rv [8] = '{32'h3030, 32'h3031, 32'h24D, 32'h30310000, 0, 0, 0, 0};
	logic [7:0] ra [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h00, 8'h40};
	logic [31:0] fs [3] = '{32'h4103, 32'h4105, 32'h4101};

	assign hready = hreadyout;

	ttl_link_host u_ttl_link_host (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

	ttl_sign_model u_ttl_sign_model (.core_clk(core_clk), .rst(rst), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.slow(slow), .fault(fault));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Edge samples taken in NBA order so tasks never race the design
	always @(posedge core_clk)
	begin
		rd_s <= hrdata;
		rdy_s <= hready;
		if (tx_valid && tx_ready)
			txq.push_back(tx_data);
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_rdy();
		int k;
		k = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			k++;
		end
		while (rdy_s !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = rd_s;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask

	function automatic ttl_byte_t hexc(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
	endfunction

	// Second SEND lands while busy and must not start another frame
	task automatic send(input logic [15:0] id, input logic [15:0] sg, input ttl_byte_t cm,
		input logic [2:0] ln, input logic [47:0] d, input logic [31:0] st);
		ttl_byte_t e [$];
		logic [7:0] s;
		logic [31:0] r;
		int k;
		txq.delete();
		wr(8'h04, {16'h0, id});
		wr(8'h08, {16'h0, sg});
		wr(8'h0C, {21'h0, ln, cm});
		wr(8'h10, d[47:16]);
		wr(8'h14, {16'h0, d[15:0]});
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h1);
		e = {id[15:8], id[7:0], sg[15:8], sg[7:0], cm};
		for (int i = 0; i < ln; i++)
			e.push_back(d[47-8*i -: 8]);
		s = 8'h00;
		foreach (e[i])
			s = s + e[i];
		e = {8'h3E, e, hexc(s[7:4]), hexc(s[3:0]), 8'h0D};
		k = 0;
		do
		begin
			rdr(8'h18, r);
			k++;
		end
		while (r[4:0] === 5'h0 && k < 200);
		if (r[4:0] === 5'h0)
		begin
			n_errors++;
			tally_and_finish();
		end
		if (st[4])
		begin
			r = r & 32'h3F;
			repeat (20) @(posedge core_clk);
			e.delete();
		end
		chk(r, st);
		chk(txq.size(), e.size());
		foreach (e[i])
			chk(txq[i], e[i]);
		wr(8'h18, 32'h1F);
	endtask

	initial
	begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		logic [31:0] r;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		slow = 1'b0;
		fault = 2'h0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		foreach (ra[i])
		begin
			rdr(ra[i], r);
			chk(r, rv[i]);
		end
		chk(txq.size(), 0);
		$display("test reset values done");
		foreach (kd[i])
			send(16'h3935, 16'h3031, 8'h4B, kd[i][7:0] ? 3'h6 : 3'h5, kd[i], 32'h4101);
		rdr(8'h1C, r);
		chk(r, 32'h3935);
		$display("test display update done");
		slow <= 1'b1;
		send(16'h6137, 16'h3031, 8'h4D, 3'h2, 48'h303100000000, 32'h104101);
		for (int j = 0; j < 4; j++)
		begin
			rdr(8'h20 + 8'(4 * j), r);
			chk(r, {8'h41 + 8'(4 * j), 8'h42 + 8'(4 * j), 8'h43 + 8'(4 * j), 8'h44 + 8'(4 * j)});
		end
		$display("test status query done");
		send(16'h3030, 16'h3032, 8'h4D, 3'h2, 48'h303100000000, 32'h24E01);
		rdr(8'h20, r);
		chk({16'h0, r[31:16]}, 32'h3033);
		$display("test refusal done");
		for (int f = 1; f < 4; f++)
		begin
			fault <= 2'(f);
			slow <= f[0];
			send(16'h3935, 16'h3031, 8'h4B, 3'h5, kd[0], fs[f-1]);
		end
		fault <= 2'h0;
		$display("test reply faults done");
		send(16'h3935, 16'h3031, 8'h4B, 3'h7, kd[0], 32'h10);
		send(16'h3935, 16'h3031, 8'h4B, 3'h5, 48'h303030306700, 32'h10);
		send(16'h3935, 16'h3031, 8'h4B, 3'h5, 48'h303130347800, 32'h10);
		send(16'h3935, 16'h3031, 8'h4D, 3'h3, 48'h303130000000, 32'h10);
		$display("test config refusal done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
